// *** bench/ifx_link_sva.sv ***
// assertion checker for the interrupt flag link
`timescale 1ns/1ps
`default_nettype none
`include "ifx_params.svh"
module ifx_link_sva
  import ifx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_stb,
  input wire logic reg_we,
  input wire ifx_addr_t reg_addr,
  input wire ifx_byte_t reg_wdata,
  input wire ifx_byte_t reg_rdata,
  input wire logic irq_req,
  input wire ifx_vec_t irq_vector,
  input wire logic irq_ack
);
  logic rd_stb;
  logic mask_q;
  ifx_byte_t wedge_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign rd_stb = reg_stb && !reg_we;
  // shadow of the processor mask bit, ack wins over a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `IFX_RST_MASK;
    end else if (irq_ack) begin
      mask_q <= 1'b1;
    end else if (reg_stb && reg_we && reg_addr == `IFX_A_COND_CODE) begin
      mask_q <= reg_wdata[0];
    end
  end
  // shadow of the wakeup edge select register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wedge_q <= `IFX_RST_BYTE;
    end else if (reg_stb && reg_we && reg_addr == `IFX_A_WAKE_EDGE) begin
      wedge_q <= reg_wdata;
    end
  end
  property p_ack_unreq;
    irq_ack |=> !irq_req;
  endproperty
  a_ack_unreq: assert property (p_ack_unreq) else $error("request still up after ack");
  property p_masked;
    mask_q && $past(mask_q) |-> !irq_req;
  endproperty
  a_masked: assert property (p_masked) else $error("request while masked");
  property p_ack_pulse;
    irq_ack |-> $past(irq_req) ##1 !irq_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bad ack pulse");
  property p_vec_range;
    irq_req |-> irq_vector inside {[4'h4:4'h9]};
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_rd_first;
    rd_stb && reg_addr == `IFX_A_FIRST_REQ |=> reg_rdata[7:5] == 3'b001;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first flags fixed bits");
  property p_rd_periph;
    rd_stb && reg_addr == `IFX_A_PERIPH_REQ |=> !reg_rdata[7] && !reg_rdata[5];
  endproperty
  a_rd_periph: assert property (p_rd_periph) else $error("periph reserved bits");
  property p_rd_wedge;
    rd_stb && reg_addr == `IFX_A_WAKE_EDGE |=> reg_rdata == wedge_q;
  endproperty
  a_rd_wedge: assert property (p_rd_wedge) else $error("wake edge readback");
  property p_rd_hold;
    !rd_stb |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped;
    rd_stb && reg_addr > `IFX_A_COND_CODE |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_wake: cover property (irq_ack && irq_vector == `IFX_V_WAKE);
  c_pin0: cover property (irq_ack && irq_vector == `IFX_V_PIN0);
  c_clear: cover property (reg_stb && reg_we && reg_addr == `IFX_A_FIRST_REQ);
endmodule
`default_nettype wire

// *** bench/interrupt_flags_and_external_irq_tb_top.sv ***
// testbench joining both ends of the interrupt flag link
`timescale 1ns/1ps
`default_nettype none
`include "ifx_params.svh"
module interrupt_flags_and_external_irq_tb_top
  import ifx_pkg::*;
;
  // {stimulus, expected peripheral flags}
  localparam logic [18:0] PT [0:12] = '{19'h00102, 19'h00202, 19'h00401, 19'h01400,
    19'h01801, 19'h02000, 19'h06010, 19'h08008, 19'h10004, 19'h30000, 19'h38008,
    19'h40040, 19'h00801};
  // {edge config, pwm pin, level, expected first flags}
  localparam logic [17:0] AT [0:8] = '{18'h00024, 18'h00120, 18'h00420, 18'h00524,
    18'h00824, 18'h00924, 18'h01420, 18'h01620, 18'h01724};
  localparam ifx_vec_t VL [0:2] = '{4'h5, 4'h7, 4'h8};
  localparam ifx_byte_t CL [0:2] = '{8'hFD, 8'hF7, 8'hEF};
  logic clk, rst_n, cmd_valid, cmd_we, cmd_ready, rsp_valid, int_valid, wake_valid;
  ifx_addr_t cmd_addr;
  ifx_byte_t cmd_wdata, rsp_data, wake_src, u_tf_upper, u_tf_lower;
  ifx_vec_t int_vector;
  logic u_tg_ovf, u_tg_ovf_en, u_tf_mode16, u_tc_ovf, u_tc_udf, up_m, lo_m;
  logic u_ec_high_ovf, u_ec_low_ovf, u_ec_mode16, u_adc_busy, u_tg_pin, u_aec_pin, u_aec_pwm;
  logic [3:0] u_ext_pins;
  ifx_byte_t u_wake_pins;
  logic [10:0] ev;
  logic [14:0] pv;
  int num_errors = 0;
  int checks_done = 0;
  ifx_vec_t ivq[$];
  ifx_byte_t wq[$];
  // peripheral events and pin levels from two bench vectors
  assign {u_adc_busy, u_tf_mode16, lo_m, up_m, u_tg_ovf_en, u_tg_ovf, u_ec_mode16,
    u_ec_high_ovf, u_ec_low_ovf, u_tc_udf, u_tc_ovf} = ev;
  assign u_tf_upper = up_m ? 8'h3C : 8'h00;
  assign u_tf_lower = lo_m ? 8'hC3 : 8'h00;
  assign {u_tg_pin, u_aec_pwm, u_aec_pin, u_ext_pins, u_wake_pins} = pv;
  ifx_link_if lk ();
  ifx_dev i_ifx_dev (.clk(clk), .rst_n(rst_n), .lnk(lk));
  ifx_host i_ifx_host (.clk(clk), .rst_n(rst_n), .lnk(lk), .cmd_valid(cmd_valid),
    .cmd_we(cmd_we), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .int_valid(int_valid),
    .int_vector(int_vector), .wake_valid(wake_valid), .wake_src(wake_src),
    .u_tg_pin(u_tg_pin), .u_tg_ovf(u_tg_ovf), .u_tg_ovf_en(u_tg_ovf_en),
    .u_tf_upper(u_tf_upper), .u_tf_lower(u_tf_lower), .u_tf_upper_cmp(8'h3C),
    .u_tf_lower_cmp(8'hC3), .u_tf_mode16(u_tf_mode16), .u_tc_ovf(u_tc_ovf),
    .u_tc_udf(u_tc_udf), .u_ec_high_ovf(u_ec_high_ovf), .u_ec_low_ovf(u_ec_low_ovf),
    .u_ec_mode16(u_ec_mode16), .u_adc_busy(u_adc_busy), .u_wake_pins(u_wake_pins),
    .u_ext_pins(u_ext_pins), .u_aec_pin(u_aec_pin), .u_aec_pwm(u_aec_pwm));
  ifx_link_sva i_ifx_link_sva (.clk(clk), .rst_n(rst_n), .reg_stb(lk.reg_stb),
    .reg_we(lk.reg_we), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
    .reg_rdata(lk.reg_rdata), .irq_req(lk.irq_req), .irq_vector(lk.irq_vector),
    .irq_ack(lk.irq_ack));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // collect accepted vectors and wakeup sources
  always @(negedge clk) begin
    if (int_valid === 1'b1) ivq.push_back(int_vector);
    if (wake_valid === 1'b1) wq.push_back(wake_src);
  end
  task automatic chk(input string nm, input ifx_byte_t e, input ifx_byte_t g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic take();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 60);
    if (n >= 60) num_errors++;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wr(input ifx_addr_t a, input ifx_byte_t d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_we <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    take();
  endtask
  task automatic rd(input ifx_addr_t a, input ifx_byte_t e, input string nm);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_we <= 1'b0;
    cmd_addr <= a;
    take();
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    if (n >= 40) num_errors++;
    chk(nm, e, rsp_data);
  endtask
  // pulse peripheral events for one cycle
  task automatic pulse(input logic [10:0] s);
    @(posedge clk);
    ev <= s;
    @(posedge clk);
    ev <= '0;
    repeat (6) @(posedge clk);
  endtask
  // move pins under mask m, then let the samplers settle
  task automatic setp(input logic [14:0] m, input logic v);
    @(posedge clk);
    pv <= v ? (pv | m) : (pv & ~m);
    repeat (6) @(posedge clk);
  endtask
  // vector 0 means no acceptance expected
  task automatic irq_chk(input ifx_vec_t e);
    int n;
    n = 0;
    while (ivq.size() == 0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk("vector", {4'h0, e}, (ivq.size() > 0) ? {4'h0, ivq.pop_front()} : 8'h00);
  endtask
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_we = 1'b0;
    cmd_addr = 4'h0;
    cmd_wdata = 8'h00;
    ev = '0;
    pv = '1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`IFX_A_FIRST_REQ, 8'h20, "first flags");
    rd(`IFX_A_PERIPH_REQ, 8'h00, "periph flags");
    rd(`IFX_A_WAKE_REQ, 8'h00, "wake flags");
    rd(`IFX_A_WAKE_EDGE, 8'h00, "wake edge");
    rd(`IFX_A_COND_CODE, 8'h01, "mask");
    rd(4'hF, 8'h00, "unmapped");
    wr(`IFX_A_WAKE_EDGE, 8'hA5);
    rd(`IFX_A_WAKE_EDGE, 8'hA5, "wake edge");
    wr(`IFX_A_PIN_FUNC, 8'h20);
    setp(15'h4000, 1'b0);
    setp(15'h4000, 1'b1);
    rd(`IFX_A_PERIPH_REQ, 8'h10, "capture flag");
    wr(`IFX_A_PERIPH_REQ, 8'h00);
    for (int i = 0; i < 13; i++) begin
      pulse(PT[i][18:8]);
      rd(`IFX_A_PERIPH_REQ, PT[i][7:0], "periph flags");
      wr(`IFX_A_PERIPH_REQ, 8'hFF);
      rd(`IFX_A_PERIPH_REQ, PT[i][7:0], "periph keep");
      wr(`IFX_A_PERIPH_REQ, 8'h00);
      rd(`IFX_A_PERIPH_REQ, 8'h00, "periph clear");
    end
    wr(`IFX_A_PIN_FUNC, 8'h0F);
    wr(`IFX_A_FIRST_EN, 8'h1E);
    wr(`IFX_A_EDGE_SEL, 8'h18);
    setp(15'h0F00, 1'b0);
    rd(`IFX_A_FIRST_REQ, 8'h23, "pin flags fall");
    setp(15'h0F00, 1'b1);
    rd(`IFX_A_FIRST_REQ, 8'h3B, "pin flags rise");
    irq_chk(4'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`IFX_A_COND_CODE, 8'h00);
      irq_chk(VL[i]);
      wr(`IFX_A_FIRST_REQ, CL[i]);
    end
    wr(`IFX_A_COND_CODE, 8'h00);
    irq_chk(4'h0);
    wr(`IFX_A_FIRST_EN, 8'h1F);
    irq_chk(`IFX_V_PIN0);
    wr(`IFX_A_FIRST_REQ, 8'hFE);
    for (int i = 0; i < 9; i++) begin
      wr(`IFX_A_AEC_EDGE, AT[i][17:10]);
      setp(AT[i][9] ? 15'h2000 : 15'h1000, AT[i][8]);
      rd(`IFX_A_FIRST_REQ, AT[i][7:0], "event pin flag");
      wr(`IFX_A_FIRST_REQ, 8'hFB);
    end
    wr(`IFX_A_FIRST_EN, 8'h1B);
    setp(15'h2000, 1'b0);
    setp(15'h2000, 1'b1);
    rd(`IFX_A_FIRST_REQ, 8'h20, "event pin disabled");
    wr(`IFX_A_FIRST_EN, 8'h1F);
    setp(15'h2000, 1'b0);
    setp(15'h2000, 1'b1);
    wr(`IFX_A_COND_CODE, 8'h00);
    irq_chk(`IFX_V_AEC);
    wr(`IFX_A_FIRST_REQ, 8'hFB);
    wr(`IFX_A_WAKE_FUNC, 8'h81);
    wr(`IFX_A_WAKE_EDGE, 8'h80);
    setp(15'h00FF, 1'b0);
    rd(`IFX_A_WAKE_REQ, 8'h01, "wake fall");
    setp(15'h00FF, 1'b1);
    rd(`IFX_A_WAKE_REQ, 8'h81, "wake rise");
    wr(`IFX_A_COND_CODE, 8'h00);
    irq_chk(4'h0);
    wr(`IFX_A_FIRST_EN, 8'h20);
    irq_chk(`IFX_V_WAKE);
    repeat (4) @(negedge clk);
    chk("wake source", 8'h81, (wq.size() > 0) ? wq.pop_front() : 8'h00);
    wr(`IFX_A_WAKE_REQ, 8'hFE);
    rd(`IFX_A_WAKE_REQ, 8'h80, "wake clear");
    end_sim();
  end
endmodule
`default_nettype wire

// *** rtl/ifx_dev.sv ***
// interrupt request flags, edge detection, masking and vector choice
// How it works
// - timer G flag: capture edge or enabled overflow
// - timer FH flag: upper or full compare match
// - timer FL flag: lower match in 8-bit mode
// - timer C flag on overflow or underflow
// - event counter flag on mode-dependent overflow
// - flags persist; written 0 clears, 1 ignored
// - software writes 0 to reserved bit 5
// - enabled wakeup pin edge sets its flag
// - edge bit: 0 falling, 1 rising
// - wakeup edge select resets to zero
// - common wakeup enable gates wakeup requests
// - mask holds requests; acceptance sets mask
// - all wakeup pins share vector 9
// - external pin edge sets first-register flag
// - per-pin enable bits gate recognition
// - pins 4,3,1,0 vectors 8,7,5,4; pin0 first
// - event counter source: pin or pwm output
// - event counter edge: rise, fall or both
// - event counter flag only while enabled
// - event counter pin uses vector 6
// - converter flag when start flag falls
`timescale 1ns/1ps
`default_nettype none
`include "ifx_params.svh"
module ifx_dev
  import ifx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ifx_link_if.dev lnk
);
  localparam int NPIN = 15;
  localparam int P_TG = 12;
  localparam int P_AEC = 13;
  localparam int P_PWM = 14;

  logic [NPIN-1:0] raw, s1_q, s2_q, s3_q;
  logic [4:0] first_req_q, first_set;
  logic [7:0] periph_req_q, periph_set;
  logic [7:0] wake_req_q, wake_set, wake_edge_q, wake_func_q;
  logic [5:0] first_en_q, pin_func_q;
  logic [4:0] edge_sel_q;
  logic [2:0] aec_edge_q;
  logic mask_q, irq_req_q, conversion_start_flag_q, fh_match_q, fl_match_q;
  ifx_vec_t vector_q, vector_d;
  ifx_byte_t rdata_q;
  logic fh_match, fl_match, aec_cur, aec_prev, aec_hit, any_pend;
  logic [5:0] pend;

  // one edge of the chosen polarity between two samples
  function automatic logic edge_hit(input logic cur, input logic prev, input logic rising);
    edge_hit = rising ? (cur && !prev) : (!cur && prev);
  endfunction

  // write strobe for one register offset
  function automatic logic wr(input ifx_addr_t a);
    wr = lnk.reg_stb && lnk.reg_we && (lnk.reg_addr == a);
  endfunction

  // write-zero-to-clear merge, set wins over a clear
  function automatic logic [7:0] w0c(input logic [7:0] q, input logic [7:0] s,
                                     input ifx_addr_t a);
    w0c = (wr(a) ? (q & lnk.reg_wdata) : q) | s;
  endfunction

  assign raw = {lnk.event_counter_pwm_output, lnk.event_counter_pin_interrupt,
                lnk.timer_g_capture_pin, lnk.ext_pins, lnk.wakeup_pins};

  // three-stage sampling; edges come from stages two and three only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // wakeup pins: per-pin function and edge choice
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_wake
      assign wake_set[gi] = wake_func_q[gi] &&
        edge_hit(s2_q[gi], s3_q[gi], wake_edge_q[gi]);
    end
  endgenerate

  // numbered external pins 0,1,3,4 onto flag bits 0,1,3,4
  localparam int FBIT [4] = '{`IFX_B_PIN4, `IFX_B_PIN3, `IFX_B_PIN1, `IFX_B_PIN0};
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ext
      assign first_set[FBIT[3-gi]] = pin_func_q[gi] &&
        edge_hit(s2_q[8+gi], s3_q[8+gi], edge_sel_q[FBIT[3-gi]]);
    end
  endgenerate

  // event counter source choice and edge field
  assign aec_cur = aec_edge_q[`IFX_B_PWM_SEL] ? s2_q[P_PWM] : s2_q[P_AEC];
  assign aec_prev = aec_edge_q[`IFX_B_PWM_SEL] ? s3_q[P_PWM] : s3_q[P_AEC];
  assign aec_hit = aec_edge_q[`IFX_B_AEC_HI] ? (aec_cur != aec_prev)
                 : edge_hit(aec_cur, aec_prev, aec_edge_q[`IFX_B_AEC_LO]);
  assign first_set[`IFX_B_AEC] = aec_hit && first_en_q[`IFX_B_AEC];

  // timer F compare conditions, flagged on the first matching cycle
  assign fh_match = lnk.tf_mode16
    ? ({lnk.timer_f_upper_counter, lnk.timer_f_lower_counter} ==
       {lnk.timer_f_upper_compare, lnk.timer_f_lower_compare})
    : (lnk.timer_f_upper_counter == lnk.timer_f_upper_compare);
  assign fl_match = !lnk.tf_mode16 &&
    (lnk.timer_f_lower_counter == lnk.timer_f_lower_compare);

  // peripheral request sources
  always_comb begin
    periph_set = 8'h00;
    periph_set[`IFX_B_TG] = (pin_func_q[`IFX_B_TG_FUNC] &&
      edge_hit(s2_q[P_TG], s3_q[P_TG], pin_func_q[`IFX_B_TG_EDGE])) ||
      (lnk.tg_overflow && lnk.overflow_irq_enable);
    periph_set[`IFX_B_TFH] = fh_match && !fh_match_q;
    periph_set[`IFX_B_TFL] = fl_match && !fl_match_q;
    periph_set[`IFX_B_TC] = lnk.tc_overflow || lnk.tc_underflow;
    periph_set[`IFX_B_EC] = lnk.ec_mode16 ? lnk.ec_high_ovf
                          : (lnk.ec_high_ovf || lnk.ec_low_ovf);
    periph_set[`IFX_B_AD] = conversion_start_flag_q && !lnk.conversion_start_flag;
  end

  // previous-cycle copies for the level-to-event conversions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conversion_start_flag_q <= 1'b0;
      fh_match_q <= 1'b1;
      fl_match_q <= 1'b1;
    end else begin
      conversion_start_flag_q <= lnk.conversion_start_flag;
      fh_match_q <= fh_match;
      fl_match_q <= fl_match;
    end
  end

  // sticky request flags; acceptance leaves them alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_req_q <= 5'h00;
      periph_req_q <= `IFX_RST_BYTE;
      wake_req_q <= `IFX_RST_BYTE;
    end else begin
      first_req_q <= 5'(w0c({3'h0, first_req_q}, {3'h0, first_set}, `IFX_A_FIRST_REQ));
      periph_req_q <= w0c(periph_req_q, periph_set, `IFX_A_PERIPH_REQ)
                    & ~(8'h01 << `IFX_B_PERIPH_RSV);
      wake_req_q <= w0c(wake_req_q, wake_set, `IFX_A_WAKE_REQ);
    end
  end

  // software-owned configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_edge_q <= `IFX_RST_BYTE;
      wake_func_q <= `IFX_RST_BYTE;
      first_en_q <= 6'h00;
      edge_sel_q <= 5'h00;
      aec_edge_q <= 3'h0;
      pin_func_q <= 6'h00;
    end else begin
      if (wr(`IFX_A_WAKE_EDGE)) wake_edge_q <= lnk.reg_wdata;
      if (wr(`IFX_A_WAKE_FUNC)) wake_func_q <= lnk.reg_wdata;
      if (wr(`IFX_A_FIRST_EN)) first_en_q <= lnk.reg_wdata[5:0];
      if (wr(`IFX_A_EDGE_SEL)) edge_sel_q <= lnk.reg_wdata[4:0] & 5'h1B;
      if (wr(`IFX_A_AEC_EDGE)) aec_edge_q <= lnk.reg_wdata[2:0];
      if (wr(`IFX_A_PIN_FUNC)) pin_func_q <= lnk.reg_wdata[5:0];
    end
  end

  // enabled pending sources, lowest index has priority
  assign pend[0] = first_req_q[`IFX_B_PIN0] && first_en_q[`IFX_B_PIN0];
  assign pend[1] = first_req_q[`IFX_B_PIN1] && first_en_q[`IFX_B_PIN1];
  assign pend[2] = first_req_q[`IFX_B_AEC] && first_en_q[`IFX_B_AEC];
  assign pend[3] = first_req_q[`IFX_B_PIN3] && first_en_q[`IFX_B_PIN3];
  assign pend[4] = first_req_q[`IFX_B_PIN4] && first_en_q[`IFX_B_PIN4];
  assign pend[5] = (|wake_req_q) && first_en_q[`IFX_B_WAKE_EN];
  assign any_pend = |pend;

  // vector for the highest-priority pending source
  always_comb begin
    if (pend[0]) vector_d = `IFX_V_PIN0;
    else if (pend[1]) vector_d = `IFX_V_PIN1;
    else if (pend[2]) vector_d = `IFX_V_AEC;
    else if (pend[3]) vector_d = `IFX_V_PIN3;
    else if (pend[4]) vector_d = `IFX_V_PIN4;
    else if (pend[5]) vector_d = `IFX_V_WAKE;
    else vector_d = `IFX_V_NONE;
  end

  // mask bit and the registered request toward the cpu
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `IFX_RST_MASK;
      irq_req_q <= 1'b0;
      vector_q <= `IFX_V_NONE;
    end else begin
      if (lnk.irq_ack) mask_q <= 1'b1;
      else if (wr(`IFX_A_COND_CODE)) mask_q <= lnk.reg_wdata[0];
      irq_req_q <= any_pend && !mask_q && !lnk.irq_ack;
      vector_q <= vector_d;
    end
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (lnk.reg_stb && !lnk.reg_we) begin
      unique case (lnk.reg_addr)
        `IFX_A_FIRST_REQ: rdata_q <= {2'b00, 1'b1, first_req_q};
        `IFX_A_PERIPH_REQ: rdata_q <= periph_req_q;
        `IFX_A_WAKE_REQ: rdata_q <= wake_req_q;
        `IFX_A_WAKE_EDGE: rdata_q <= wake_edge_q;
        `IFX_A_FIRST_EN: rdata_q <= {2'b00, first_en_q};
        `IFX_A_EDGE_SEL: rdata_q <= {3'b000, edge_sel_q};
        `IFX_A_AEC_EDGE: rdata_q <= {5'b00000, aec_edge_q};
        `IFX_A_PIN_FUNC: rdata_q <= {2'b00, pin_func_q};
        `IFX_A_WAKE_FUNC: rdata_q <= wake_func_q;
        `IFX_A_COND_CODE: rdata_q <= {7'h00, mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign lnk.reg_rdata = rdata_q;
  assign lnk.irq_req = irq_req_q;
  assign lnk.irq_vector = vector_q;
endmodule
`default_nettype wire

// *** rtl/ifx_host.sv ***
// cpu/peripheral end: register access, interrupt acceptance, stimulus drive
`timescale 1ns/1ps
`default_nettype none
`include "ifx_params.svh"
module ifx_host
  import ifx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ifx_link_if.host lnk,
  input wire logic cmd_valid,
  input wire logic cmd_we,
  input wire ifx_addr_t cmd_addr,
  input wire ifx_byte_t cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output ifx_byte_t rsp_data,
  output logic int_valid,
  output ifx_vec_t int_vector,
  output logic wake_valid,
  output ifx_byte_t wake_src,
  input wire logic u_tg_pin,
  input wire logic u_tg_ovf,
  input wire logic u_tg_ovf_en,
  input wire ifx_byte_t u_tf_upper,
  input wire ifx_byte_t u_tf_lower,
  input wire ifx_byte_t u_tf_upper_cmp,
  input wire ifx_byte_t u_tf_lower_cmp,
  input wire logic u_tf_mode16,
  input wire logic u_tc_ovf,
  input wire logic u_tc_udf,
  input wire logic u_ec_high_ovf,
  input wire logic u_ec_low_ovf,
  input wire logic u_ec_mode16,
  input wire logic u_adc_busy,
  input wire ifx_byte_t u_wake_pins,
  input wire logic [3:0] u_ext_pins,
  input wire logic u_aec_pin,
  input wire logic u_aec_pwm
);
  ifx_host_state_e state_q;
  logic stb_q, we_q, ack_q, wake_rd_q;
  ifx_addr_t addr_q;
  ifx_byte_t wdata_q;
  logic take_irq;

  // accept an interrupt when raised and not just acknowledged
  assign take_irq = (state_q == IFX_H_IDLE) && lnk.irq_req && !ack_q;
  assign cmd_ready = (state_q == IFX_H_IDLE) && !take_irq;

  assign lnk.reg_stb = stb_q;
  assign lnk.reg_we = we_q;
  assign lnk.reg_addr = addr_q;
  assign lnk.reg_wdata = wdata_q;
  assign lnk.irq_ack = ack_q;

  // sequencer for bus strobes and interrupt acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= IFX_H_IDLE;
      stb_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      ack_q <= 1'b0;
      wake_rd_q <= 1'b0;
    end else begin
      stb_q <= 1'b0;
      we_q <= 1'b0;
      ack_q <= 1'b0;
      unique case (state_q)
        IFX_H_IDLE: begin
          if (take_irq) begin
            ack_q <= 1'b1;
            if (lnk.irq_vector == `IFX_V_WAKE) begin
              // shared vector: fetch the wakeup flags to find the pin
              stb_q <= 1'b1;
              addr_q <= `IFX_A_WAKE_REQ;
              wake_rd_q <= 1'b1;
              state_q <= IFX_H_WAIT;
            end
          end else if (cmd_valid) begin
            stb_q <= 1'b1;
            we_q <= cmd_we;
            addr_q <= cmd_addr;
            // flag writes pass as given, except periph reserved bit 5 forced to 0: a 0 clears, a 1 keeps
            wdata_q <= cmd_wdata;
            if (cmd_we && cmd_addr == `IFX_A_PERIPH_REQ) begin
              wdata_q[`IFX_B_PERIPH_RSV] <= 1'b0;
            end
            wake_rd_q <= 1'b0;
            if (!cmd_we) begin
              state_q <= IFX_H_WAIT;
            end
          end
        end
        IFX_H_WAIT: state_q <= IFX_H_TAKE;
        IFX_H_TAKE: state_q <= IFX_H_IDLE;
      endcase
    end
  end

  // read results and accepted vectors toward the user
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      int_valid <= 1'b0;
      int_vector <= 4'h0;
      wake_valid <= 1'b0;
      wake_src <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      wake_valid <= 1'b0;
      int_valid <= take_irq;
      if (take_irq) begin
        int_vector <= lnk.irq_vector;
      end
      if (state_q == IFX_H_TAKE) begin
        if (wake_rd_q) begin
          wake_valid <= 1'b1;
          wake_src <= lnk.reg_rdata;
        end else begin
          rsp_valid <= 1'b1;
          rsp_data <= lnk.reg_rdata;
        end
      end
    end
  end

  // peripheral and pin levels registered onto the link
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lnk.timer_g_capture_pin <= 1'b1;
      lnk.tg_overflow <= 1'b0;
      lnk.overflow_irq_enable <= 1'b0;
      lnk.timer_f_upper_counter <= 8'h00;
      lnk.timer_f_lower_counter <= 8'h00;
      lnk.timer_f_upper_compare <= 8'hFF;
      lnk.timer_f_lower_compare <= 8'hFF;
      lnk.tf_mode16 <= 1'b0;
      lnk.tc_overflow <= 1'b0;
      lnk.tc_underflow <= 1'b0;
      lnk.ec_high_ovf <= 1'b0;
      lnk.ec_low_ovf <= 1'b0;
      lnk.ec_mode16 <= 1'b0;
      lnk.conversion_start_flag <= 1'b0;
      lnk.wakeup_pins <= 8'hFF;
      lnk.ext_pins <= 4'hF;
      lnk.event_counter_pin_interrupt <= 1'b1;
      lnk.event_counter_pwm_output <= 1'b1;
    end else begin
      lnk.timer_g_capture_pin <= u_tg_pin;
      lnk.tg_overflow <= u_tg_ovf;
      lnk.overflow_irq_enable <= u_tg_ovf_en;
      lnk.timer_f_upper_counter <= u_tf_upper;
      lnk.timer_f_lower_counter <= u_tf_lower;
      lnk.timer_f_upper_compare <= u_tf_upper_cmp;
      lnk.timer_f_lower_compare <= u_tf_lower_cmp;
      lnk.tf_mode16 <= u_tf_mode16;
      lnk.tc_overflow <= u_tc_ovf;
      lnk.tc_underflow <= u_tc_udf;
      lnk.ec_high_ovf <= u_ec_high_ovf;
      lnk.ec_low_ovf <= u_ec_low_ovf;
      lnk.ec_mode16 <= u_ec_mode16;
      lnk.conversion_start_flag <= u_adc_busy;
      lnk.wakeup_pins <= u_wake_pins;
      lnk.ext_pins <= u_ext_pins;
      // both event counter sources go out; the device picks one
      lnk.event_counter_pin_interrupt <= u_aec_pin;
      lnk.event_counter_pwm_output <= u_aec_pwm;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ifx_link_if.sv ***
// signals between the interrupt flag block and the cpu/peripheral side
`timescale 1ns/1ps
`default_nettype none
interface ifx_link_if;
  import ifx_pkg::*;
  logic reg_stb;
  logic reg_we;
  ifx_addr_t reg_addr;
  ifx_byte_t reg_wdata;
  ifx_byte_t reg_rdata;
  logic irq_req;
  ifx_vec_t irq_vector;
  logic irq_ack;
  logic timer_g_capture_pin;
  logic tg_overflow;
  logic overflow_irq_enable;
  ifx_byte_t timer_f_upper_counter;
  ifx_byte_t timer_f_lower_counter;
  ifx_byte_t timer_f_upper_compare;
  ifx_byte_t timer_f_lower_compare;
  logic tf_mode16;
  logic tc_overflow;
  logic tc_underflow;
  logic ec_high_ovf;
  logic ec_low_ovf;
  logic ec_mode16;
  logic conversion_start_flag;
  ifx_byte_t wakeup_pins;
  logic [3:0] ext_pins;
  logic event_counter_pin_interrupt;
  logic event_counter_pwm_output;

  modport dev (
    input reg_stb, reg_we, reg_addr, reg_wdata, irq_ack,
    input timer_g_capture_pin, tg_overflow, overflow_irq_enable,
    input timer_f_upper_counter, timer_f_lower_counter,
    input timer_f_upper_compare, timer_f_lower_compare, tf_mode16,
    input tc_overflow, tc_underflow, ec_high_ovf, ec_low_ovf, ec_mode16,
    input conversion_start_flag, wakeup_pins, ext_pins,
    input event_counter_pin_interrupt, event_counter_pwm_output,
    output reg_rdata, irq_req, irq_vector
  );
  modport host (
    output reg_stb, reg_we, reg_addr, reg_wdata, irq_ack,
    output timer_g_capture_pin, tg_overflow, overflow_irq_enable,
    output timer_f_upper_counter, timer_f_lower_counter,
    output timer_f_upper_compare, timer_f_lower_compare, tf_mode16,
    output tc_overflow, tc_underflow, ec_high_ovf, ec_low_ovf, ec_mode16,
    output conversion_start_flag, wakeup_pins, ext_pins,
    output event_counter_pin_interrupt, event_counter_pwm_output,
    input reg_rdata, irq_req, irq_vector
  );
endinterface
`default_nettype wire

// *** rtl/ifx_params.svh ***
// offsets, field positions, reset values and vectors of the interrupt flag block
`ifndef IFX_PARAMS_SVH
`define IFX_PARAMS_SVH

// register offsets on the register port
`define IFX_A_FIRST_REQ   4'h0
`define IFX_A_PERIPH_REQ  4'h1
`define IFX_A_WAKE_REQ    4'h2
`define IFX_A_WAKE_EDGE   4'h3
`define IFX_A_FIRST_EN    4'h4
`define IFX_A_EDGE_SEL    4'h5
`define IFX_A_AEC_EDGE    4'h6
`define IFX_A_PIN_FUNC    4'h7
`define IFX_A_WAKE_FUNC   4'h8
`define IFX_A_COND_CODE   4'h9

// first request flag / enable register bit positions
`define IFX_B_PIN0        0
`define IFX_B_PIN1        1
`define IFX_B_AEC         2
`define IFX_B_PIN3        3
`define IFX_B_PIN4        4
`define IFX_B_WAKE_EN     5
`define IFX_B_FIRST_ONE   5

// peripheral request flag bit positions
`define IFX_B_EC          0
`define IFX_B_TC          1
`define IFX_B_TFL         2
`define IFX_B_TFH         3
`define IFX_B_TG          4
`define IFX_B_PERIPH_RSV  5
`define IFX_B_AD          6

// event counter edge register fields
`define IFX_B_AEC_LO      0
`define IFX_B_AEC_HI      1
`define IFX_B_PWM_SEL     2

// pin function register fields
`define IFX_B_TG_EDGE     4
`define IFX_B_TG_FUNC     5

// reset values
`define IFX_RST_BYTE      8'h00
`define IFX_RST_MASK      1'b1

// vector numbers
`define IFX_V_PIN0        4'h4
`define IFX_V_PIN1        4'h5
`define IFX_V_AEC         4'h6
`define IFX_V_PIN3        4'h7
`define IFX_V_PIN4        4'h8
`define IFX_V_WAKE        4'h9
`define IFX_V_NONE        4'h0

`endif

// *** rtl/ifx_pkg.sv ***
// types shared by both ends of the interrupt flag block
package ifx_pkg;
  typedef logic [3:0] ifx_addr_t;
  typedef logic [7:0] ifx_byte_t;
  typedef logic [3:0] ifx_vec_t;
  typedef enum logic [2:0] {
    IFX_H_IDLE = 3'b001,
    IFX_H_WAIT = 3'b010,
    IFX_H_TAKE = 3'b100
  } ifx_host_state_e;
endpackage
